// [rtl/pin_sync.sv]
// module: three-flop synchroniser bank with agreed-level edge detection
`timescale 1ns/100ps
module pin_sync (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   pin_sync_if.sync pins
);
   import pport_pkg::*;
   //==============================================================
   // per-lane synchroniser
   genvar g;
   generate
      for (g = 0; g < SYNC_LANES; g++) begin : lane
         logic s1_q;
         logic s2_q;
         logic s3_q;
         logic lvl_q;
         always_ff @(posedge core_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               s1_q <= 1'b1;
               s2_q <= 1'b1;
               s3_q <= 1'b1;
            end else begin
               s1_q <= pins.raw[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
            end
         end
         // agreed level only
         // a change counts once stage two and three agree, so one edge
         // yields one pulse even if the pin rings near the sample point
         always_ff @(posedge core_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               lvl_q <= 1'b1;
            end else if (s2_q == s3_q) begin
               lvl_q <= s3_q;
            end
         end
         assign pins.level[g] = lvl_q;
         assign pins.rise[g] = (s2_q == s3_q) && s3_q && !lvl_q;
         assign pins.fall[g] = (s2_q == s3_q) && !s3_q && lvl_q;
      end
   endgenerate
endmodule

// [rtl/pin_sync_if.sv]
// interface: synchronised pin levels and edge pulses
`timescale 1ns/100ps
interface pin_sync_if;
   import pport_pkg::*;
   logic [SYNC_LANES-1:0] raw;
   logic [SYNC_LANES-1:0] level;
   logic [SYNC_LANES-1:0] rise;
   logic [SYNC_LANES-1:0] fall;
   modport sync (input raw, output level, rise, fall);
   modport user (output raw, input level, rise, fall);
endinterface

// [rtl/pport_pkg.sv]
// package: register map, field layout, reset values and pin-side constants
//==============================================================
// Overview of operation
// - transmitter mode: control bit 6 drives pin B, forming printer strobe.
// - transmitter mode: pin A shows the output-full flag.
// - transmitter mode: output strobe rising edge clears output-full flag.
// - transmitter mode: input strobe falling edge (busy end) sets input-full flag.
// - output-only mode: data drivers always on; output strobe only clears flag.
// - control value 64h selects the output-only transmitter setup.
// - CPU read of port data clears the input-full flag.
// - receiver mode: input-full flag on pin B acts as busy.
// - receiver mode: input strobe rising edge latches data, sets input-full.
// - receiver mode: control bit 4 drives pin A, the acknowledge line.
// - firmware configures receiver with 9Ch, then dummy-reads port data.
// - transmitter sends next byte after acknowledge rise or busy fall.
// - transmitter holds strobe low about 6 us via control bit 6.
// - transmitter waits busy low, outputs data, dummy-reads, then strobes.
// - receiver: ack low, read byte after delay, ack high after delay.
// - pin A with output-full flag feeds falling-edge interrupt.
// - timer lets transmitter retransmit current byte after long silence.
// - link uses eleven lines: eight data, strobe, busy, acknowledge.
// - hardware reset sets control bits 2 to 7 to one.
//==============================================================
package pport_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_DATA = 8'h04;
   localparam logic [7:0] ADDR_PINS = 8'h08;
   localparam int ADDR_W = 8;
   // control/status field positions
   localparam int BIT_PIN_B_MODE_HIGH = 7;
   localparam int BIT_PIN_B_MODE_LOW = 6;
   localparam int BIT_PIN_A_MODE_HIGH = 5;
   localparam int BIT_PIN_A_MODE_LOW = 4;
   localparam int BIT_OUTPUT_FLAG_CONTROL = 3;
   localparam int BIT_INPUT_STROBE_MODE = 2;
   localparam int BIT_OUTPUT_FULL = 1;
   localparam int BIT_INPUT_FULL = 0;
   localparam logic [7:0] CONTROL_WRITE_MASK = 8'hFC;
   localparam logic [7:0] CONTROL_RESET = 8'hFC;
   localparam logic [7:0] CONFIG_TRANSMITTER = 8'h64;
   localparam logic [7:0] CONFIG_RECEIVER = 8'h9C;
   // pins-register layout
   localparam int PINS_DATA_LSB = 0;
   localparam int PINS_INPUT_STROBE = 8;
   localparam int PINS_OUTPUT_STROBE = 9;
   localparam int PINS_PIN_A = 10;
   localparam int PINS_PIN_B = 11;
   // synchronised input lanes
   localparam int SYNC_LANES = 4;
   localparam int LANE_INPUT_STROBE = 0;
   localparam int LANE_OUTPUT_STROBE = 1;
   localparam int LANE_PIN_A = 2;
   localparam int LANE_PIN_B = 3;
   localparam int SYNC_STAGES = 3;
   // timing: nominal strobe width kept by firmware through bit 6
   localparam int CLK_PERIOD_NS = 10;
   localparam int STROBE_WIDTH_US = 6;
   localparam int STROBE_WIDTH_CYCLES = STROBE_WIDTH_US * 1000 / CLK_PERIOD_NS;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [1:0] HRESP_OKAY = 2'b00;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ_WAIT = 2'b10,
      BUS_READ_DONE = 2'b11
   } bus_state_t;
endpackage

// [rtl/pport_top.sv]
// module: parallel printer port handshake with AHB-Lite register slave
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/100ps
module pport_top (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic [1:0] hresp_o,
   // eight two-way data lines
   input wire logic [7:0] port_data_i,
   output logic [7:0] port_data_o,
   output logic [7:0] port_data_oe_n_o,
   // strobe inputs
   input wire logic input_strobe_pin_i,
   input wire logic output_strobe_pin_i,
   // handshake flag pins (two-way)
   input wire logic handshake_pin_a_i,
   output logic handshake_pin_a_o,
   output logic handshake_pin_a_oe_n_o,
   input wire logic handshake_pin_b_i,
   output logic handshake_pin_b_o,
   output logic handshake_pin_b_oe_n_o
);
   import pport_pkg::*;

   //==============================================================
   // declarations
   pin_sync_if sync_bus ();
   bus_state_t state_q;
   logic [ADDR_W-1:0] addr_q;
   logic [7:0] mode_q;
   logic input_full_q;
   logic output_full_q;
   logic [7:0] in_latch_q;
   logic [7:0] out_latch_q;
   logic [7:0] data_in_q;
   logic [31:0] rdata_q;
   logic addr_valid;
   logic rd_take;
   logic wr_commit;
   logic rd_data_clear;
   logic wr_control;
   logic wr_data;
   logic pin_b_sw_output;
   logic pin_b_is_input;
   logic pin_a_is_input;
   logic output_only;
   logic port_enabled;
   logic ids_set_edge;
   logic ods_clear_edge;
   logic [31:0] read_mux;

   //==============================================================
   // pin synchronisers
   assign sync_bus.raw[LANE_INPUT_STROBE] = input_strobe_pin_i;
   assign sync_bus.raw[LANE_OUTPUT_STROBE] = output_strobe_pin_i;
   assign sync_bus.raw[LANE_PIN_A] = handshake_pin_a_i;
   assign sync_bus.raw[LANE_PIN_B] = handshake_pin_b_i;

   pin_sync u_sync (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .pins(sync_bus.sync)
   );

   // data lines pass one flop every cycle and are latched only at an input strobe
   // edge, which has already passed three flops, so the bus has long been settled
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         data_in_q <= 8'h00;
      end else begin
         data_in_q <= port_data_i;
      end
   end

   //==============================================================
   // mode decode
   // pin B: 0x = software output of bit 6, 10 = input-full flag,
   //        11 = port enable input
   // pin A: 0x = software output of bit 4, 10 = output-full flag,
   //        11 = input (port select; no internal effect)
   assign pin_b_sw_output = !mode_q[BIT_PIN_B_MODE_HIGH];
   assign pin_b_is_input = mode_q[BIT_PIN_B_MODE_HIGH] &&
                           mode_q[BIT_PIN_B_MODE_LOW];
   assign pin_a_is_input = mode_q[BIT_PIN_A_MODE_HIGH] &&
                           mode_q[BIT_PIN_A_MODE_LOW];
   // output-only setup
   // both flag pins outputs with pin B under software: 64h lands here
   assign output_only = pin_b_sw_output && !pin_a_is_input;
   // a high port-enable input turns the drivers off and blocks strobe edges to latch and flags
   assign port_enabled = !(pin_b_is_input &&
                           sync_bus.level[LANE_PIN_B]);

   // busy falling edge sets flag
   // in output-only mode the input latch is unused and the falling
   // edge records the end of busy; elsewhere the rising edge latches
   assign ids_set_edge = output_only ?
                         sync_bus.fall[LANE_INPUT_STROBE] :
                         (sync_bus.rise[LANE_INPUT_STROBE] && port_enabled);
   assign ods_clear_edge = sync_bus.rise[LANE_OUTPUT_STROBE] &&
                           (output_only || port_enabled);

   //==============================================================
   // AHB-Lite slave
   // writes complete with no wait state; reads add one so the answer
   // comes from a register and already reflects a write just before
   assign addr_valid = (haddr_i[ADDR_W-1:0] == ADDR_CONTROL) ||
                       (haddr_i[ADDR_W-1:0] == ADDR_DATA) ||
                       (haddr_i[ADDR_W-1:0] == ADDR_PINS);
   assign rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
   assign wr_commit = (state_q == BUS_WRITE);
   assign wr_control = wr_commit && (addr_q == ADDR_CONTROL);
   assign wr_data = wr_commit && (addr_q == ADDR_DATA);
   assign rd_data_clear = (state_q == BUS_READ_WAIT) &&
                          (addr_q == ADDR_DATA);

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= BUS_IDLE;
         addr_q <= 8'h00;
      end else begin
         unique case (state_q)
            BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
               if (hsel_i && hready_i && htrans_i[1]) begin
                  addr_q <= addr_valid ? haddr_i[ADDR_W-1:0] : 8'hFF;
                  state_q <= hwrite_i ? BUS_WRITE : BUS_READ_WAIT;
               end else begin
                  state_q <= BUS_IDLE;
               end
            end
            BUS_READ_WAIT: begin
               state_q <= BUS_READ_DONE;
            end
         endcase
      end
   end

   assign hreadyout_o = (state_q != BUS_READ_WAIT);
   assign hresp_o = HRESP_OKAY;
   assign hrdata_o = rdata_q;

   always_comb begin
      read_mux = 32'h0000_0000;
      unique case (addr_q)
         ADDR_CONTROL: begin
            read_mux[7:0] = {mode_q[7:2], output_full_q, input_full_q};
         end
         ADDR_DATA: begin
            read_mux[7:0] = in_latch_q;
         end
         ADDR_PINS: begin
            read_mux[PINS_DATA_LSB +: 8] = data_in_q;
            read_mux[PINS_INPUT_STROBE] = sync_bus.level[LANE_INPUT_STROBE];
            read_mux[PINS_OUTPUT_STROBE] =
               sync_bus.level[LANE_OUTPUT_STROBE];
            read_mux[PINS_PIN_A] = sync_bus.level[LANE_PIN_A];
            read_mux[PINS_PIN_B] = sync_bus.level[LANE_PIN_B];
         end
         default: begin
            read_mux = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (state_q == BUS_READ_WAIT) begin
         rdata_q <= read_mux;
      end
   end

   //==============================================================
   // control register
   // bits 2..7 reset high
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_q <= CONTROL_RESET;
      end else if (wr_control) begin
         mode_q <= hwdata_i[7:0] & CONTROL_WRITE_MASK;
      end
   end

   //==============================================================
   // input-full flag and input latch
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         input_full_q <= 1'b0;
      end else if (ids_set_edge) begin
         // strobe edge wins over a clearing read in the same cycle
         input_full_q <= 1'b1;
      end else if (rd_data_clear) begin
         input_full_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         in_latch_q <= 8'h00;
      end else if (ids_set_edge && !output_only) begin
         in_latch_q <= data_in_q;
      end
   end

   //==============================================================
   // output latch and output-full flag
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         out_latch_q <= 8'h00;
      end else if (wr_data) begin
         out_latch_q <= hwdata_i[7:0];
      end
   end

   // rewrite restarts a byte
   // a rewrite of the same byte after a long silence sets the flag
   // again, so a retransmission is tracked like a fresh byte
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         output_full_q <= 1'b0;
      end else if (wr_data) begin
         output_full_q <= 1'b1;
      end else if (ods_clear_edge) begin
         output_full_q <= 1'b0;
      end
   end

   //==============================================================
   // data drivers
   // output-only drivers always on
   // eight data lines driven
   // outside output-only mode the strobe enables drivers while low
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         port_data_oe_n_o <= 8'hFF;
         port_data_o <= 8'h00;
      end else begin
         port_data_o <= out_latch_q;
         if (output_only) begin
            port_data_oe_n_o <= 8'h00;
         end else if (port_enabled &&
                      !sync_bus.level[LANE_OUTPUT_STROBE]) begin
            port_data_oe_n_o <= 8'h00;
         end else begin
            port_data_oe_n_o <= 8'hFF;
         end
      end
   end

   //==============================================================
   // handshake flag pins
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         handshake_pin_b_o <= 1'b1;
         handshake_pin_b_oe_n_o <= 1'b1;
      end else begin
         handshake_pin_b_oe_n_o <= pin_b_is_input;
         if (pin_b_sw_output) begin
            handshake_pin_b_o <= mode_q[BIT_PIN_B_MODE_LOW];
         end else begin
            handshake_pin_b_o <= input_full_q;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         handshake_pin_a_o <= 1'b1;
         handshake_pin_a_oe_n_o <= 1'b1;
      end else begin
         handshake_pin_a_oe_n_o <= pin_a_is_input;
         if (mode_q[BIT_PIN_A_MODE_HIGH]) begin
            handshake_pin_a_o <= output_full_q;
         end else begin
            handshake_pin_a_o <= mode_q[BIT_PIN_A_MODE_LOW];
         end
      end
   end

endmodule

// [verification/pport_chk.sv]
// checker: bus timing and pin relations of the printer port
`timescale 1ns/100ps
module pport_chk (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   input wire logic hreadyout_o,
   input wire logic [1:0] hresp_o,
   input wire logic [7:0] port_data_oe_n_o,
   input wire logic input_strobe_pin_i,
   input wire logic output_strobe_pin_i,
   input wire logic handshake_pin_a_o,
   input wire logic handshake_pin_b_o,
   input wire logic handshake_pin_b_oe_n_o
);
   import pport_pkg::*;
   logic req;
   logic wr_ctl_q;
   logic wr_dat_q;
   logic rd_dat_q;
   logic [7:0] ctrl_q;
   logic [1:0] settle_q;
   logic tx_mode;
   logic rx_mode;
   assign req = hsel_i && hready_i && htrans_i[1];
   // a mode counts only once the registered pins had time to follow
   assign tx_mode = !ctrl_q[7] && ctrl_q[5:4] != 2'h3 && settle_q[1];
   assign rx_mode = ctrl_q[7:6] == 2'h2 && !ctrl_q[5] && settle_q[1];
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ctl_q <= 1'b0;
         wr_dat_q <= 1'b0;
         rd_dat_q <= 1'b0;
      end else begin
         wr_ctl_q <= req && hwrite_i && haddr_i[7:0] == ADDR_CONTROL;
         wr_dat_q <= req && hwrite_i && haddr_i[7:0] == ADDR_DATA;
         rd_dat_q <= req && !hwrite_i && haddr_i[7:0] == ADDR_DATA;
      end
   end
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_q <= CONTROL_RESET;
         settle_q <= 2'h2;
      end else if (wr_ctl_q) begin
         ctrl_q <= hwdata_i[7:0] & CONTROL_WRITE_MASK;
         settle_q <= 2'h0;
      end else if (!settle_q[1]) begin
         settle_q <= settle_q + 2'h1;
      end
   end
   //=====================================
   // assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   property p_okay; hresp_o == HRESP_OKAY; endproperty
   a_okay: assert property (p_okay) else $error("bad response");
   property p_rd_wait; req && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
   property p_wr_now; req && hwrite_i |=> hreadyout_o; endproperty
   a_wr_now: assert property (p_wr_now) else $error("write stalled");
   property p_rst; $rose(resetn_i) |->
      port_data_oe_n_o == 8'hFF && handshake_pin_b_oe_n_o; endproperty
   a_rst: assert property (p_rst) else $error("pins driven at reset");
   property p_bit6; tx_mode |->
      handshake_pin_b_o == ctrl_q[6] && !handshake_pin_b_oe_n_o; endproperty
   a_bit6: assert property (p_bit6) else $error("pin b not bit 6");
   property p_drv; tx_mode |-> port_data_oe_n_o == 8'h00; endproperty
   a_drv: assert property (p_drv) else $error("drivers off");
   property p_full_a; tx_mode && ctrl_q[5] && wr_dat_q |->
      ##[1:3] handshake_pin_a_o; endproperty
   a_full_a: assert property (p_full_a) else $error("pin a not full");
   property p_ack_clr; tx_mode && ctrl_q[5] && $rose(output_strobe_pin_i)
      |-> ##[4:8] !handshake_pin_a_o; endproperty
   a_ack_clr: assert property (p_ack_clr) else $error("full kept");
   property p_latch; rx_mode && $rose(input_strobe_pin_i) |->
      ##[4:8] handshake_pin_b_o; endproperty
   a_latch: assert property (p_latch) else $error("busy not set");
   property p_bit4; rx_mode |-> handshake_pin_a_o == ctrl_q[4]; endproperty
   a_bit4: assert property (p_bit4) else $error("pin a not bit 4");
   property p_rd_clr; rx_mode && rd_dat_q |-> ##[1:4] !handshake_pin_b_o;
   endproperty
   a_rd_clr: assert property (p_rd_clr) else $error("busy kept");
endmodule
bind pport_top pport_chk chk_u (
   .core_clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
   .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .port_data_oe_n_o,
   .input_strobe_pin_i, .output_strobe_pin_i, .handshake_pin_a_o,
   .handshake_pin_b_o, .handshake_pin_b_oe_n_o);

// [verification/pport_top_tb.sv]
// testbench: printer port transmit and receive over the register bus
`timescale 1ns/100ps
module pport_top_tb;
   import pport_pkg::*;
   logic core_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] peer_mode = 2'h0;
   logic [31:0] rv;
   int bad_count = 0;
   int tests_run = 0;
   wire [31:0] hrdata;
   wire hready;
   wire [7:0] dev_data;
   wire [7:0] data_oe_n;
   wire [7:0] peer_data;
   wire [7:0] line_data;
   wire pin_a_o, pin_a_oe_n, pin_b_o, pin_b_oe_n, istb, ostb;
   // flag pins carry pull-ups
   wire pin_a_w = pin_a_oe_n ? 1'b1 : pin_a_o;
   wire pin_b_w = pin_b_oe_n ? 1'b1 : pin_b_o;
   assign line_data = (dev_data & ~data_oe_n) | (peer_data & data_oe_n);
   always #5 core_clk_i = ~core_clk_i;
   pport_top dut_u (
      .core_clk_i(core_clk_i), .resetn_i(resetn_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
      .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
      .port_data_i(line_data), .port_data_o(dev_data),
      .port_data_oe_n_o(data_oe_n), .input_strobe_pin_i(istb),
      .output_strobe_pin_i(ostb), .handshake_pin_a_i(pin_a_w),
      .handshake_pin_a_o(pin_a_o), .handshake_pin_a_oe_n_o(pin_a_oe_n),
      .handshake_pin_b_i(pin_b_w), .handshake_pin_b_o(pin_b_o),
      .handshake_pin_b_oe_n_o(pin_b_oe_n));
   printer_peer peer_u (
      .core_clk_i(core_clk_i), .mode_i(peer_mode), .strobe_i(pin_b_w),
      .data_i(line_data), .data_o(peer_data), .busy_o(istb), .ack_o(ostb));
   //=====================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %0t: saw %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      if (bad_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (hready !== 1'b1 && n < 40);
      if (hready !== 1'b1) begin
         $display("Error %0t: bus hang", $time);
         bad_count++;
         end_sim();
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_rdy();
      rv = hrdata;
   endtask
   // bounded poll of one register bit
   task automatic poll(input logic [7:0] a, input int b, input logic v);
      int n;
      n = 0;
      do begin
         xfer(1'b0, a, 8'h00);
         n++;
      end while (rv[b] !== v && n < 400);
      chk(rv[b], v);
      if (rv[b] !== v) end_sim();
   endtask
   //=====================================
   // scenarios
   task automatic t_reset();
      xfer(1'b0, ADDR_CONTROL, 8'h00);
      chk(rv, {24'h0, CONTROL_RESET});
      chk({data_oe_n, pin_a_oe_n, pin_b_oe_n}, 10'h3FF);
      xfer(1'b0, 8'h0C, 8'h00);
      chk(rv, 32'h0);
   endtask
   task automatic t_tx(input logic [1:0] style, input logic [7:0] d);
      peer_mode <= style;
      xfer(1'b1, ADDR_CONTROL, CONFIG_TRANSMITTER);
      xfer(1'b0, ADDR_CONTROL, 8'h00);
      chk(rv & 32'hFFFF_FFFC, {24'h0, CONFIG_TRANSMITTER});
      chk({data_oe_n, pin_b_oe_n, pin_b_o}, 10'h001);
      poll(ADDR_PINS, PINS_INPUT_STROBE, 1'b0);
      xfer(1'b1, ADDR_DATA, d);
      xfer(1'b0, ADDR_DATA, 8'h00);
      xfer(1'b0, ADDR_CONTROL, 8'h00);
      chk(rv[1:0], 2'h2);
      chk({dev_data, pin_a_o}, {d, 1'b1});
      xfer(1'b1, ADDR_CONTROL, 8'h24);
      repeat (3) @(posedge core_clk_i);
      chk(pin_b_o, 1'b0);
      repeat (STROBE_WIDTH_CYCLES) @(posedge core_clk_i);
      xfer(1'b1, ADDR_CONTROL, CONFIG_TRANSMITTER);
      if (style != 2'h2) poll(ADDR_CONTROL, BIT_OUTPUT_FULL, 1'b0);
      else poll(ADDR_CONTROL, BIT_INPUT_FULL, 1'b1);
      chk(rv[1:0], {style == 2'h2, style != 2'h3});
      repeat (3) @(posedge core_clk_i);
      chk(pin_a_o, style == 2'h2);
      chk(peer_u.got_q, d);
      xfer(1'b0, ADDR_DATA, 8'h00);
      xfer(1'b0, ADDR_CONTROL, 8'h00);
      chk(rv[0], 1'b0);
   endtask
   task automatic t_rx();
      logic [7:0] vals [2] = '{8'h5A, 8'hC3};
      peer_mode <= 2'h0;
      repeat (8) @(posedge core_clk_i);
      xfer(1'b1, ADDR_CONTROL, CONFIG_RECEIVER);
      xfer(1'b0, ADDR_DATA, 8'h00);
      xfer(1'b0, ADDR_CONTROL, 8'h00);
      // output-full is still pending from the silent printer
      chk(rv, {24'h0, CONFIG_RECEIVER | 8'h02});
      chk({pin_a_o, data_oe_n}, 9'h1FF);
      xfer(1'b1, ADDR_CONTROL, 8'h8C);
      repeat (3) @(posedge core_clk_i);
      chk(pin_a_o, 1'b0);
      foreach (vals[i]) begin
         peer_u.send(vals[i]);
         repeat (4) @(posedge core_clk_i);
         chk(pin_b_o, 1'b1);
         xfer(1'b0, ADDR_DATA, 8'h00);
         chk(rv, {24'h0, vals[i]});
         repeat (3) @(posedge core_clk_i);
         chk(pin_b_o, 1'b0);
      end
   endtask
   initial begin
      repeat (20) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      @(posedge core_clk_i);
      t_reset();
      t_tx(2'h1, 8'h3C);
      // ack-only printer next: the busy-only one runs last and must leave output-full set
      t_tx(2'h3, 8'h96);
      t_tx(2'h2, 8'hE1);
      t_rx();
      end_sim();
   end
   initial begin
      repeat (100000) @(posedge core_clk_i);
      $display("Error %0t: run too long", $time);
      bad_count++;
      end_sim();
   end
endmodule

// [verification/printer_peer.sv]
// model: printer, or sending host when mode is zero, beyond the port
`timescale 1ns/100ps
module printer_peer #(
   parameter int BUSY_CYC = 20,
   parameter int ACK_CYC = 8
) (
   input wire logic core_clk_i,
   input wire logic [1:0] mode_i,
   input wire logic strobe_i,
   input wire logic [7:0] data_i,
   output logic [7:0] data_o,
   output logic busy_o,
   output logic ack_o
);
   logic busy_q = 1'b0;
   logic strb_q = 1'b1;
   logic [7:0] got_q = 8'h00;
   initial data_o = 8'h00;
   initial ack_o = 1'b1;
   // as sender the busy line carries the data strobe instead
   assign busy_o = (mode_i == 2'h0) ? strb_q : busy_q;
   //=====================================
   // printer side
   // busy per byte
   // mode 3 acks with no busy; mode 1 acks after busy ends
   always @(posedge strobe_i) begin
      if (mode_i != 2'h0) begin
         got_q <= data_i;
         repeat (2) @(posedge core_clk_i);
         busy_q <= (mode_i != 2'h3);
         repeat (BUSY_CYC) @(posedge core_clk_i);
         busy_q <= 1'b0;
         if (mode_i[0]) begin
            repeat (2) @(posedge core_clk_i);
            ack_o <= 1'b0;
            repeat (ACK_CYC) @(posedge core_clk_i);
            ack_o <= 1'b1;
         end
      end
   end
   // data, then strobe; lines scrambled once held long enough
   task automatic send(input logic [7:0] d);
      @(posedge core_clk_i);
      data_o <= d;
      repeat (3) @(posedge core_clk_i);
      strb_q <= 1'b0;
      repeat (10) @(posedge core_clk_i);
      strb_q <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      data_o <= ~d;
   endtask
endmodule
